/* File: hw/vc_resource_regs.sv */
`timescale 1ns/1ps
module vc_resource_regs
    import vc_resource_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration space access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [3:0] i_cfg_be,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // Strap and default autoload
    input wire logic i_ext_vc_count,
    input wire logic i_autoload_valid,
    input wire logic [7:0] i_autoload_tc_map,
    input wire logic [6:0] i_autoload_max_slots,
    // Arbitration hardware
    input wire logic i_table_entry_write,
    input wire logic i_table_load_done,
    input wire logic i_negotiation_pending,
    output logic o_table_load,
    output logic o_table_status,
    // VC0 configuration
    output logic [7:0] o_tc_map,
    output logic [2:0] o_arb_select,
    output logic o_vc_enable
);

    logic ext_count;
    logic load_busy;
    logic pending;
    logic [6:0] max_slots;
    logic [31:0] control_word;
    logic [31:0] status_word;
    logic [31:0] capability_word;
    logic [31:0] next_rdata;
    logic ctl_wr;

    assign ctl_wr = i_cfg_wr && (i_cfg_addr == ADDR_VC0_CONTROL);

    function automatic logic [2:0] legal_select(input logic [2:0] value);
        if (value == ARB_SEL_WEIGHTED) begin
            return ARB_SEL_WEIGHTED;
        end
        return ARB_SEL_DEFAULT;
    endfunction

    // Strap caught while reset is held
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_count <= i_ext_vc_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tc_map <= TC_MAP_RESET;
        end else if (ctl_wr && i_cfg_be[0]) begin
            o_tc_map <= i_cfg_wdata[CTL_TC_MAP_LSB +: 8];
        end else if (i_autoload_valid) begin
            o_tc_map <= i_autoload_tc_map;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arb_select <= ARB_SEL_DEFAULT;
        end else if (ctl_wr && i_cfg_be[2]) begin
            o_arb_select <= legal_select(i_cfg_wdata[CTL_ARB_SEL_LSB +: 3]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_vc_enable <= VC_ENABLE_RESET;
        end else if (ctl_wr && i_cfg_be[3]) begin
            o_vc_enable <= i_cfg_wdata[CTL_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_table_load <= 1'b0;
        end else begin
            o_table_load <= ctl_wr && i_cfg_be[2] && i_cfg_wdata[CTL_LOAD_BIT];
        end
    end

    // Load in flight until the hardware reports done
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_busy <= 1'b0;
        end else if (o_table_load) begin
            load_busy <= 1'b1;
        end else if (i_table_load_done) begin
            load_busy <= 1'b0;
        end
    end

    // entry write wins over load finish
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_table_status <= 1'b0;
        end else if (i_table_entry_write) begin
            o_table_status <= 1'b1;
        end else if (load_busy && i_table_load_done) begin
            o_table_status <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pending <= 1'b0;
        end else begin
            pending <= i_negotiation_pending;
        end
    end

    // slot count, strap default, autoload override
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            max_slots <= i_ext_vc_count ? SLOTS_VC1 : SLOTS_NONE;
        end else if (i_autoload_valid) begin
            max_slots <= i_autoload_max_slots;
        end
    end

    always_comb begin
        control_word = 32'h0;
        control_word[CTL_TC_MAP_LSB +: 8] = o_tc_map;
        control_word[CTL_LOAD_BIT] = 1'b0;
        control_word[CTL_ARB_SEL_LSB +: 3] = o_arb_select;
        control_word[CTL_VC_ID_LSB +: 3] = VC0_ID;
        control_word[CTL_ENABLE_BIT] = o_vc_enable;
    end

    always_comb begin
        status_word = 32'h0;
        status_word[STS_TABLE_BIT] = o_table_status;
        status_word[STS_PENDING_BIT] = pending;
    end

    always_comb begin
        capability_word = 32'h0;
        capability_word[CAP_ARB_LSB +: 8] =
            ext_count ? ARB_CAP_VC1 : ARB_CAP_NONE;
        capability_word[CAP_APS_BIT] = 1'b0;
        capability_word[CAP_SNOOP_BIT] = 1'b0;
        capability_word[CAP_SLOTS_LSB +: 7] = max_slots;
        capability_word[CAP_OFFSET_LSB +: 8] =
            ext_count ? OFFSET_VC1 : OFFSET_NONE;
    end

    always_comb begin
        case (i_cfg_addr)
            ADDR_VC0_CONTROL: begin
                next_rdata = control_word;
            end
            ADDR_VC0_STATUS: begin
                next_rdata = status_word;
            end
            ADDR_VC1_CAPABILITY: begin
                next_rdata = capability_word;
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg_rdata <= 32'h0;
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
            o_cfg_rdata <= i_cfg_rd ? next_rdata : 32'h0;
        end
    end

endmodule

/* File: include/vc_resource_pkg.sv */
package vc_resource_pkg;

    // Register byte addresses in configuration space
    localparam logic [11:0] ADDR_VC0_CONTROL = 12'h154;
    localparam logic [11:0] ADDR_VC0_STATUS = 12'h158;
    localparam logic [11:0] ADDR_VC1_CAPABILITY = 12'h15c;

    // Control word fields
    localparam int CTL_TC_MAP_LSB = 0;
    localparam int CTL_LOAD_BIT = 16;
    localparam int CTL_ARB_SEL_LSB = 17;
    localparam int CTL_VC_ID_LSB = 24;
    localparam int CTL_ENABLE_BIT = 31;

    // Status word fields
    localparam int STS_TABLE_BIT = 16;
    localparam int STS_PENDING_BIT = 17;

    // Capability word fields
    localparam int CAP_ARB_LSB = 0;
    localparam int CAP_APS_BIT = 14;
    localparam int CAP_SNOOP_BIT = 15;
    localparam int CAP_SLOTS_LSB = 16;
    localparam int CAP_OFFSET_LSB = 24;

    // Reset and fixed values
    localparam logic [7:0] TC_MAP_RESET = 8'hff;
    localparam logic [2:0] ARB_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] ARB_SEL_WEIGHTED = 3'h3;
    localparam logic [2:0] VC0_ID = 3'h0;
    localparam logic VC_ENABLE_RESET = 1'b1;

    // Capability values for extended VC count of zero and one
    localparam logic [7:0] ARB_CAP_NONE = 8'h00;
    localparam logic [7:0] ARB_CAP_VC1 = 8'h19;
    localparam logic [6:0] SLOTS_NONE = 7'h00;
    localparam logic [6:0] SLOTS_VC1 = 7'h7f;
    localparam logic [7:0] OFFSET_NONE = 8'h00;
    localparam logic [7:0] OFFSET_VC1 = 8'h08;

    // Arbitration table phases; table offset counts sixteen_byte_unit
    localparam int ARB_PHASES = 128;
    localparam int SIXTEEN_BYTE_UNIT = 16;

endpackage

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import vc_resource_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_ext_vc_count = 1'b1;
    logic i_autoload_valid = 1'b0, i_table_entry_write = 1'b0;
    logic i_table_load_done = 1'b0, i_negotiation_pending = 1'b0;
    logic [11:0] i_cfg_addr = 12'h0;
    logic [31:0] i_cfg_wdata = 32'h0;
    logic [3:0] i_cfg_be = 4'h0;
    logic [7:0] i_autoload_tc_map = 8'h3c;
    logic [6:0] i_autoload_max_slots = 7'h11;
    logic [31:0] o_cfg_rdata;
    logic o_cfg_rvalid, o_table_load, o_table_status, o_vc_enable;
    logic [7:0] o_tc_map;
    logic [2:0] o_arb_select;
    int n_errors = 0, num_checks = 0, cyc = 0;

    vc_resource_regs i_vc_resource_regs (.*);

    always #2.5 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step;
        s = 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        i_cfg_wr = 1'b1;
        i_cfg_addr = a;
        i_cfg_wdata = d;
        i_cfg_be = be;
        step;
        i_cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        i_cfg_rd = 1'b1;
        i_cfg_addr = a;
        step;
        i_cfg_rd = 1'b0;
        chk({31'h0, o_cfg_rvalid}, 32'h1);
        chk(o_cfg_rdata, e);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_errors++;
            results;
        end
    end

    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        rd(ADDR_VC0_CONTROL, 32'h800000ff);
        rd(ADDR_VC0_STATUS, 32'h0);
        rd(ADDR_VC1_CAPABILITY, 32'h087f0019);
        rd(12'h150, 32'h0);
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_VC0_CONTROL, {8'h7f, 4'hf, s[2:0], 9'h1ff, 5'h0, s[2:0]},
               4'hf);
            chk({29'h0, o_arb_select}, (s == 3) ? 32'h3 : 32'h0);
            chk({31'h0, o_vc_enable}, 32'h0);
            rd(ADDR_VC0_CONTROL, {12'h0, (s == 3) ? 3'h3 : 3'h0, 14'h0,
               s[2:0]});
        end
        wr(ADDR_VC0_CONTROL, 32'h80000000, 4'h8);
        chk({31'h0, o_vc_enable}, 32'h1);
        rd(ADDR_VC0_CONTROL, 32'h80000007);
        wr(ADDR_VC1_CAPABILITY, 32'hffffffff, 4'hf);
        wr(ADDR_VC0_STATUS, 32'hffffffff, 4'hf);
        rd(ADDR_VC1_CAPABILITY, 32'h087f0019);
        $display("test writes done");
        pulse(i_table_load_done);
        pulse(i_table_entry_write);
        pulse(i_table_load_done);
        rd(ADDR_VC0_STATUS, 32'h00010000);
        wr(ADDR_VC0_CONTROL, 32'h00010000, 4'h4);
        chk({31'h0, o_table_load}, 32'h1);
        step;
        chk({31'h0, o_table_load}, 32'h0);
        pulse(i_table_load_done);
        chk({31'h0, o_table_status}, 32'h0);
        i_negotiation_pending = 1'b1;
        repeat (2) step;
        rd(ADDR_VC0_STATUS, 32'h00020000);
        i_negotiation_pending = 1'b0;
        repeat (2) step;
        rd(ADDR_VC0_STATUS, 32'h0);
        $display("test status done");
        pulse(i_autoload_valid);
        chk({24'h0, o_tc_map}, 32'h3c);
        rd(ADDR_VC1_CAPABILITY, 32'h08110019);
        i_ext_vc_count = 1'b0;
        i_rst = 1'b1;
        step;
        i_rst = 1'b0;
        rd(ADDR_VC1_CAPABILITY, 32'h0);
        rd(ADDR_VC0_CONTROL, 32'h800000ff);
        $display("test strap done");
        results;
    end
endmodule

/* File: verif/vc_resource_regs_asserts.sv */
`timescale 1ns/1ps
module vc_resource_regs_asserts
    import vc_resource_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic o_cfg_rvalid,
    input wire logic i_table_entry_write,
    input wire logic o_table_load,
    input wire logic o_table_status,
    input wire logic [7:0] o_tc_map,
    input wire logic [2:0] o_arb_select,
    input wire logic o_vc_enable
);
    wire logic cw = i_cfg_wr && i_cfg_addr == ADDR_VC0_CONTROL;
    wire logic [2:0] ws = i_cfg_wdata[19:17];
    wire logic [7:0] wt = i_cfg_wdata[7:0];
    wire logic we = i_cfg_wdata[31];
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    AST_TC: assert property (cw && i_cfg_be[0] |=> o_tc_map == $past(wt))
        else $error("tc map not written");
    AST_LOAD: assert property (cw && i_cfg_be[2] && i_cfg_wdata[16]
        |=> o_table_load ##1 !o_table_load) else $error("bad load pulse");
    AST_SEL: assert property (cw && i_cfg_be[2] |=> o_arb_select ==
        ($past(ws) == ARB_SEL_WEIGHTED ? ARB_SEL_WEIGHTED : ARB_SEL_DEFAULT))
        else $error("bad arbitration select");
    AST_CTLRD: assert property (i_cfg_rd && i_cfg_addr == ADDR_VC0_CONTROL
        |=> o_cfg_rdata[26:16] == {VC0_ID, 4'h0, $past(o_arb_select), 1'b0})
        else $error("bad control read");
    AST_ENA: assert property (cw && i_cfg_be[3] |=> o_vc_enable == $past(we))
        else $error("enable not written");
    AST_SET: assert property (i_table_entry_write |=> o_table_status)
        else $error("table status not set");
    AST_STAT: assert property (i_cfg_rd && i_cfg_addr == ADDR_VC0_STATUS
        |=> o_cfg_rvalid && o_cfg_rdata[16] == $past(o_table_status))
        else $error("bad status read");
    AST_CAP: assert property (i_cfg_rd && i_cfg_addr == ADDR_VC1_CAPABILITY
        |=> o_cfg_rdata[15:8] == 8'h00 && !o_cfg_rdata[23])
        else $error("bad capability read");
    AST_IDLE: assert property (!o_cfg_rvalid |-> o_cfg_rdata == 32'h0)
        else $error("read data without valid");
endmodule

bind vc_resource_regs vc_resource_regs_asserts i_vc_resource_regs_asserts (.*);
